//--- hw/dlc_consts.svh
// Offsets, field positions, reset values and timing counts of the bank.
`ifndef DLC_CONSTS_SVH
`define DLC_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DLC_OFS_PEER_ADDR 8'h00
`define DLC_OFS_OWN_ADDR 8'h01
`define DLC_OFS_LINK_CFG 8'h02
`define DLC_OFS_CAL_CFG 8'h03

// ****************************************************************
// Field positions
// ****************************************************************
`define DLC_ADDR_MSB 7
`define DLC_ADDR_LSB 1
`define DLC_SS_MSB 7
`define DLC_SS_LSB 6
`define DLC_AUDIO_BIT 4
`define DLC_PIXEL_CLOCK_RANGE_MSB 3
`define DLC_PIXEL_CLOCK_RANGE_LSB 2
`define DLC_SERIAL_RATE_RANGE_MSB 1
`define DLC_SERIAL_RATE_RANGE_LSB 0
`define DLC_RECAL_MSB 7
`define DLC_RECAL_LSB 6
`define DLC_SAWTOOTH_DIVIDER_MSB 4
`define DLC_SAWTOOTH_DIVIDER_LSB 0
`define DLC_STRAP_A_MSB 7
`define DLC_STRAP_A_LSB 6
`define DLC_STRAP_B_MSB 3
`define DLC_STRAP_B_LSB 2

// ****************************************************************
// Writable bit masks; reserved bits are zero here
// ****************************************************************
`define DLC_MASK_ADDR 8'hfe
`define DLC_MASK_LINK 8'hdf
`define DLC_MASK_CAL 8'hdf

// ****************************************************************
// Reset values, before the strap pins are folded in
// ****************************************************************
`define DLC_RST_PEER_ADDR 8'h00
`define DLC_RST_OWN_ADDR 8'h10
`define DLC_RST_LINK_CFG 8'h1f
`define DLC_RST_CAL_CFG 8'h00
`define DLC_SS_STRAP_HIGH 2'h1
`define DLC_SS_STRAP_LOW 2'h0
`define DLC_SAWTOOTH_DIVIDER_AUTO 5'h00
`define DLC_RANGE_AUTO 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define DLC_CLK_KHZ 125000
`define DLC_RECAL_A_MS 2
`define DLC_RECAL_B_MS 16
`define DLC_RECAL_C_MS 256

`endif

//--- hw/dlc_pkg.sv
// Types shared by the link configuration bank.
package dlc_pkg;

  typedef enum logic [1:0] {
    DLC_LVL_LOW = 2'b00,
    DLC_LVL_OPEN = 2'b01,
    DLC_LVL_HIGH = 2'b10
  } dlc_level_t;

  typedef enum logic [1:0] {
    DLC_RECAL_ONCE = 2'b00,
    DLC_RECAL_2MS = 2'b01,
    DLC_RECAL_16MS = 2'b10,
    DLC_RECAL_256MS = 2'b11
  } dlc_recal_t;

  typedef enum logic [1:0] {
    DLC_TMR_IDLE = 2'b00,
    DLC_TMR_RUN = 2'b01,
    DLC_TMR_DONE = 2'b10
  } dlc_tmr_state_t;

endpackage

//--- hw/dlc_strap_decode.sv
// Turns the two three-level strap pins into default device addresses.
`timescale 1ns/10ps
`include "dlc_consts.svh"

module dlc_strap_decode (
  // Strap levels
  input wire logic [1:0] address_strap_a_i,
  input wire logic [1:0] address_strap_b_i,
  // Default addresses
  output logic [7:0] peer_default_o,
  output logic [7:0] own_default_o
);

  // Low, open and high give 00, 01 and 10; an illegal code reads as open.
  function automatic logic [1:0] dlc_level_code(input logic [1:0] lvl);
    logic [1:0] code;
    code = 2'h1;
    case (lvl)
      dlc_pkg::DLC_LVL_LOW: code = 2'h0;
      dlc_pkg::DLC_LVL_HIGH: code = 2'h2;
      default: code = 2'h1;
    endcase
    return code;
  endfunction

  always_comb begin
    peer_default_o = `DLC_RST_PEER_ADDR;
    own_default_o = `DLC_RST_OWN_ADDR;
    peer_default_o[`DLC_STRAP_A_MSB:`DLC_STRAP_A_LSB] =
      dlc_level_code(address_strap_a_i);
    peer_default_o[`DLC_STRAP_B_MSB:`DLC_STRAP_B_LSB] =
      dlc_level_code(address_strap_b_i);
    own_default_o[`DLC_STRAP_A_MSB:`DLC_STRAP_A_LSB] =
      dlc_level_code(address_strap_a_i);
    own_default_o[`DLC_STRAP_B_MSB:`DLC_STRAP_B_LSB] =
      dlc_level_code(address_strap_b_i);
  end

endmodule

//--- hw/dlc_recal_timer.sv
// Paces spread-modulation recalibration requests after link lock.
`timescale 1ns/10ps

module dlc_recal_timer #(
  parameter int unsigned CYC_A = 250000,
  parameter int unsigned CYC_B = 2000000,
  parameter int unsigned CYC_C = 32000000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic lock_i,
  input wire logic [1:0] interval_i,
  // Request
  output logic recal_o
);

  if (CYC_A < 1 || CYC_B < 1 || CYC_C < 1) begin : g_bad_cyc
    $error("recalibration intervals must be at least one cycle");
  end

  dlc_pkg::dlc_tmr_state_t state;
  logic [31:0] count;
  logic [31:0] period;
  logic lock_q;
  logic lock_rise;

  assign lock_rise = lock_i && !lock_q;

  always_comb begin
    case (dlc_pkg::dlc_recal_t'(interval_i))
      dlc_pkg::DLC_RECAL_2MS: period = CYC_A;
      dlc_pkg::DLC_RECAL_16MS: period = CYC_B;
      dlc_pkg::DLC_RECAL_256MS: period = CYC_C;
      default: period = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_i;
    end
  end

  // A request goes out at lock, then once per period while locked.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= dlc_pkg::DLC_TMR_IDLE;
      count <= 32'h0;
      recal_o <= 1'b0;
    end else begin
      recal_o <= 1'b0;
      case (state)
        dlc_pkg::DLC_TMR_IDLE: begin
          if (lock_rise) begin
            recal_o <= 1'b1;
            count <= 32'h1;
            state <= (period == 32'h0) ? dlc_pkg::DLC_TMR_DONE :
                     dlc_pkg::DLC_TMR_RUN;
          end
        end
        dlc_pkg::DLC_TMR_RUN: begin
          if (!lock_i) begin
            state <= dlc_pkg::DLC_TMR_IDLE;
          end else if (period == 32'h0) begin
            state <= dlc_pkg::DLC_TMR_DONE;
          end else if (count >= period) begin
            recal_o <= 1'b1;
            count <= 32'h1;
          end else begin
            count <= count + 32'h1;
          end
        end
        dlc_pkg::DLC_TMR_DONE: begin
          if (!lock_i) begin
            state <= dlc_pkg::DLC_TMR_IDLE;
          end else if (period != 32'h0) begin
            count <= 32'h1;
            state <= dlc_pkg::DLC_TMR_RUN;
          end
        end
        default: state <= dlc_pkg::DLC_TMR_IDLE;
      endcase
    end
  end

endmodule

//--- hw/dlc_regs.sv
// Link configuration register bank, offsets 0x00 to 0x03.
//
// Notes on behaviour
// - Offset 0x00 bits 7:1 hold the peer serializer address, strap default.
// - Offset 0x01 bits 7:1 hold this device's address, strap default.
// - Offset 0x02 bits 7:6 pick spread: none, 2 percent, none, 4 percent.
// - Offset 0x02 bit 4 enables the audio serial port; it starts at 1.
// - Offset 0x02 bits 3:2 pick pixel clock range; 11 means auto, default.
// - Offset 0x02 bits 1:0 pick serial rate range; 11 means auto, default.
// - Offset 0x03 bits 7:6 set recalibration: once, 2, 16 or 256 ms.
// - Offset 0x03 bits 4:0 hold sawtooth divider; zero means auto.
`timescale 1ns/10ps
`include "dlc_consts.svh"

module dlc_regs #(
  parameter int unsigned RECAL_CYC_A = `DLC_RECAL_A_MS * (`DLC_CLK_KHZ),
  parameter int unsigned RECAL_CYC_B = `DLC_RECAL_B_MS * (`DLC_CLK_KHZ),
  parameter int unsigned RECAL_CYC_C = `DLC_RECAL_C_MS * (`DLC_CLK_KHZ)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Strap pins; address strap levels coded low 00, open 01, high 10, spread strap is one bit
  input wire logic [1:0] address_strap_a_i,
  input wire logic [1:0] address_strap_b_i,
  input wire logic spread_strap_pin_i,
  // Register access from the control channel decoder
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_wack_o,
  output logic reg_err_o,
  // Device address matching for incoming control frames
  input wire logic [6:0] frame_addr_i,
  input wire logic frame_addr_valid_i,
  output logic own_addr_hit_o,
  output logic peer_addr_hit_o,
  // Link status
  input wire logic lock_i,
  // Configuration outputs
  output logic [6:0] peer_serializer_address_o,
  output logic [6:0] own_device_address_o,
  output logic spread_enable_o,
  output logic spread_wide_o,
  output logic audio_port_enable_o,
  output logic [1:0] pixel_clock_range_o,
  output logic pixel_range_auto_o,
  output logic [1:0] serial_rate_range_o,
  output logic serial_rate_auto_o,
  output logic [1:0] spread_recal_interval_o,
  output logic spread_recal_o,
  output logic [4:0] sawtooth_divider_o,
  output logic sawtooth_auto_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // The timer needs a nonzero period for every periodic interval code.
  if (RECAL_CYC_A < 1) begin : g_bad_cyc_a
    $error("recalibration count A must be at least one");
  end
  // A longer interval code must never give a shorter period.
  if (RECAL_CYC_B < RECAL_CYC_A) begin : g_bad_cyc_b
    $error("recalibration count B must not be below count A");
  end
  if (RECAL_CYC_C < RECAL_CYC_B) begin : g_bad_cyc_c
    $error("recalibration count C must not be below count B");
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] peer_serializer_address;
  logic [7:0] own_device_address;
  logic [7:0] link_rate_audio_spread_config;
  logic [7:0] spread_calibration_config;
  logic strap_load;
  logic [7:0] peer_default;
  logic [7:0] own_default;
  logic [7:0] link_default;
  logic wr_peer;
  logic wr_own;
  logic wr_link;
  logic wr_cal;
  logic addr_mapped;
  logic [7:0] next_rdata;
  logic recal_pulse;

  // ****************************************************************
  // Strap defaults
  // ****************************************************************
  dlc_strap_decode u_strap (
    .address_strap_a_i(address_strap_a_i),
    .address_strap_b_i(address_strap_b_i),
    .peer_default_o(peer_default),
    .own_default_o(own_default)
  );

  always_comb begin
    link_default = `DLC_RST_LINK_CFG;
    link_default[`DLC_SS_MSB:`DLC_SS_LSB] = spread_strap_pin_i ?
      `DLC_SS_STRAP_HIGH : `DLC_SS_STRAP_LOW;
  end

  // Straps are sampled on the first edge after reset release.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= 1'b0;
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  always_comb begin
    addr_mapped = 1'b1;
    case (reg_addr_i)
      `DLC_OFS_PEER_ADDR,
      `DLC_OFS_OWN_ADDR,
      `DLC_OFS_LINK_CFG,
      `DLC_OFS_CAL_CFG: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  // Writes during the strap load cycle are dropped so defaults land first.
  assign wr_peer = reg_wr_i && !strap_load &&
                   (reg_addr_i == `DLC_OFS_PEER_ADDR);
  assign wr_own = reg_wr_i && !strap_load &&
                  (reg_addr_i == `DLC_OFS_OWN_ADDR);
  assign wr_link = reg_wr_i && !strap_load &&
                   (reg_addr_i == `DLC_OFS_LINK_CFG);
  assign wr_cal = reg_wr_i && !strap_load &&
                  (reg_addr_i == `DLC_OFS_CAL_CFG);

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      peer_serializer_address <= `DLC_RST_PEER_ADDR;
    end else if (strap_load) begin
      peer_serializer_address <= peer_default;
    end else if (wr_peer) begin
      peer_serializer_address <= reg_wdata_i & `DLC_MASK_ADDR;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_device_address <= `DLC_RST_OWN_ADDR;
    end else if (strap_load) begin
      own_device_address <= own_default;
    end else if (wr_own) begin
      own_device_address <= reg_wdata_i & `DLC_MASK_ADDR;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_rate_audio_spread_config <= `DLC_RST_LINK_CFG;
    end else if (strap_load) begin
      link_rate_audio_spread_config <= link_default;
    end else if (wr_link) begin
      link_rate_audio_spread_config <= reg_wdata_i & `DLC_MASK_LINK;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spread_calibration_config <= `DLC_RST_CAL_CFG;
    end else if (wr_cal) begin
      spread_calibration_config <= reg_wdata_i & `DLC_MASK_CAL;
    end
  end

  // ****************************************************************
  // Read path and access answers
  // ****************************************************************
  always_comb begin
    case (reg_addr_i)
      `DLC_OFS_PEER_ADDR: next_rdata = peer_serializer_address;
      `DLC_OFS_OWN_ADDR: next_rdata = own_device_address;
      `DLC_OFS_LINK_CFG: next_rdata = link_rate_audio_spread_config;
      `DLC_OFS_CAL_CFG: next_rdata = spread_calibration_config;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // A write is acknowledged one cycle later; unmapped offsets flag an error.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_wack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else begin
      reg_wack_o <= reg_wr_i && !strap_load && addr_mapped;
      reg_err_o <= (reg_wr_i || reg_rd_i) && !addr_mapped;
    end
  end

  // ****************************************************************
  // Frame address match
  // ****************************************************************
  // A new address takes effect on the next frame, so the controller can
  // address the owner first and then update the peer copy.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_addr_hit_o <= 1'b0;
      peer_addr_hit_o <= 1'b0;
    end else begin
      own_addr_hit_o <= frame_addr_valid_i && (frame_addr_i ==
        own_device_address[`DLC_ADDR_MSB:`DLC_ADDR_LSB]);
      peer_addr_hit_o <= frame_addr_valid_i && (frame_addr_i ==
        peer_serializer_address[`DLC_ADDR_MSB:`DLC_ADDR_LSB]);
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  assign peer_serializer_address_o =
    peer_serializer_address[`DLC_ADDR_MSB:`DLC_ADDR_LSB];
  assign own_device_address_o =
    own_device_address[`DLC_ADDR_MSB:`DLC_ADDR_LSB];

  // Codes 01 and 11 spread; 00 and 10 do not. Bit 7 widens to 4 percent.
  assign spread_enable_o =
    link_rate_audio_spread_config[`DLC_SS_LSB];
  assign spread_wide_o = link_rate_audio_spread_config[`DLC_SS_LSB] &&
    link_rate_audio_spread_config[`DLC_SS_MSB];
  assign audio_port_enable_o =
    link_rate_audio_spread_config[`DLC_AUDIO_BIT];
  assign pixel_clock_range_o =
    link_rate_audio_spread_config[`DLC_PIXEL_CLOCK_RANGE_MSB:`DLC_PIXEL_CLOCK_RANGE_LSB];
  assign serial_rate_range_o =
    link_rate_audio_spread_config[`DLC_SERIAL_RATE_RANGE_MSB:`DLC_SERIAL_RATE_RANGE_LSB];
  assign spread_recal_interval_o =
    spread_calibration_config[`DLC_RECAL_MSB:`DLC_RECAL_LSB];
  assign sawtooth_divider_o =
    spread_calibration_config[`DLC_SAWTOOTH_DIVIDER_MSB:`DLC_SAWTOOTH_DIVIDER_LSB];

  // The auto flags are kept in flip-flops and load with their fields.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pixel_range_auto_o <= 1'b1;
      serial_rate_auto_o <= 1'b1;
    end else if (strap_load) begin
      pixel_range_auto_o <= (link_default[`DLC_PIXEL_CLOCK_RANGE_MSB:`DLC_PIXEL_CLOCK_RANGE_LSB] ==
        `DLC_RANGE_AUTO);
      serial_rate_auto_o <= (link_default[`DLC_SERIAL_RATE_RANGE_MSB:`DLC_SERIAL_RATE_RANGE_LSB] ==
        `DLC_RANGE_AUTO);
    end else if (wr_link) begin
      pixel_range_auto_o <= (reg_wdata_i[`DLC_PIXEL_CLOCK_RANGE_MSB:`DLC_PIXEL_CLOCK_RANGE_LSB] ==
        `DLC_RANGE_AUTO);
      serial_rate_auto_o <= (reg_wdata_i[`DLC_SERIAL_RATE_RANGE_MSB:`DLC_SERIAL_RATE_RANGE_LSB] ==
        `DLC_RANGE_AUTO);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sawtooth_auto_o <= 1'b1;
    end else if (wr_cal) begin
      sawtooth_auto_o <= (reg_wdata_i[`DLC_SAWTOOTH_DIVIDER_MSB:`DLC_SAWTOOTH_DIVIDER_LSB] ==
        `DLC_SAWTOOTH_DIVIDER_AUTO);
    end
  end

  // ****************************************************************
  // Recalibration pacing
  // ****************************************************************
  dlc_recal_timer #(
    .CYC_A(RECAL_CYC_A),
    .CYC_B(RECAL_CYC_B),
    .CYC_C(RECAL_CYC_C)
  ) u_recal (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .lock_i(lock_i),
    .interval_i(spread_recal_interval_o),
    .recal_o(recal_pulse)
  );

  // Requests only matter while some spread is selected.
  assign spread_recal_o = recal_pulse && spread_enable_o;

endmodule

//--- tb/dlc_regs_assertions.sv
// Concurrent checks on the link configuration bank ports.
`timescale 1ns/10ps

module dlc_regs_chk #(
  parameter int unsigned RECAL_CYC_A = 4
) (
  // Clock and reset
  input logic clk_i,
  input logic nrst_i,
  // Register access
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [7:0] reg_rdata_o,
  input logic reg_rvalid_o,
  input logic reg_wack_o,
  input logic reg_err_o,
  // Frame match and link
  input logic [6:0] frame_addr_i,
  input logic frame_addr_valid_i,
  input logic own_addr_hit_o,
  input logic lock_i,
  // Configuration
  input logic [6:0] own_device_address_o,
  input logic spread_enable_o,
  input logic spread_wide_o,
  input logic [1:0] pixel_clock_range_o,
  input logic pixel_range_auto_o,
  input logic [1:0] spread_recal_interval_o,
  input logic spread_recal_o,
  input logic [4:0] sawtooth_divider_o,
  input logic sawtooth_auto_o
);
  logic [31:0] gap;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Counts cycles since the last request while the link stays locked.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap <= 32'h0;
    end else if (spread_recal_o || !lock_i) begin
      gap <= 32'h0;
    end else begin
      gap <= gap + 32'h1;
    end
  end

  wr_ack_a: assert property ($past(nrst_i) && reg_wr_i
    && reg_addr_i < 8'h04 |=> reg_wack_o) else $error("write not acked");
  unmapped_err_a: assert property ($past(nrst_i)
    && (reg_wr_i || reg_rd_i) && reg_addr_i > 8'h03 |=> reg_err_o)
    else $error("unmapped access without error");
  reserved_zero_a: assert property (reg_rvalid_o |->
    (($past(reg_addr_i) < 8'h02) ? !reg_rdata_o[0] : !reg_rdata_o[5]))
    else $error("reserved bit read as one");
  own_write_a: assert property ($past(nrst_i) && reg_wr_i
    && reg_addr_i == 8'h01 |=> {own_device_address_o, 1'b0}
    == ($past(reg_wdata_i) & 8'hfe)) else $error("own address not written");
  own_hold_a: assert property ($past(nrst_i) && !reg_wr_i
    |=> $stable(own_device_address_o)) else $error("own address drifted");
  own_hit_a: assert property (frame_addr_valid_i
    && frame_addr_i == own_device_address_o |=> own_addr_hit_o)
    else $error("own address frame missed");
  pix_auto_a: assert property (
    pixel_range_auto_o == (pixel_clock_range_o == 2'h3))
    else $error("pixel auto flag wrong");
  saw_auto_a: assert property (
    sawtooth_auto_o == (sawtooth_divider_o == 5'h00))
    else $error("sawtooth auto flag wrong");
  spread_gate_a: assert property (
    spread_recal_o || spread_wide_o |-> spread_enable_o)
    else $error("spread outputs without spread");
  lock_recal_a: assert property (
    $rose(lock_i) && spread_enable_o |=> spread_recal_o)
    else $error("no request after lock");
  recal_period_a: assert property (lock_i && spread_enable_o
    && spread_recal_interval_o == 2'h1 && gap == RECAL_CYC_A - 1
    |-> spread_recal_o) else $error("periodic request missed");
endmodule

bind dlc_regs dlc_regs_chk #(.RECAL_CYC_A(RECAL_CYC_A)) i_chk (
  .clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .reg_rvalid_o, .reg_wack_o, .reg_err_o, .frame_addr_i,
  .frame_addr_valid_i, .own_addr_hit_o, .lock_i, .own_device_address_o,
  .spread_enable_o, .spread_wide_o, .pixel_clock_range_o,
  .pixel_range_auto_o, .spread_recal_interval_o, .spread_recal_o,
  .sawtooth_divider_o, .sawtooth_auto_o
);

//--- tb/dlc_mcu_model.sv
// Controller model issuing register accesses over the control channel.
`timescale 1ns/10ps

module dlc_mcu_model (
  // Clock
  input logic clk_i,
  // Register access
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input logic [7:0] reg_rdata_i,
  input logic reg_rvalid_i,
  input logic reg_wack_i,
  input logic reg_err_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // One strobe cycle; afterwards the bus is inverted so stale values fail.
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      input logic w, output logic [7:0] q,
                      output logic ok, output logic e);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= w;
    reg_rd_o <= !w;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
    q = reg_rdata_i;
    ok = w ? reg_wack_i : reg_rvalid_i;
    e = reg_err_i;
  endtask
endmodule

//--- tb/tb_deser_link_config_registers.sv
// Self-checking bench for the link configuration bank.
`timescale 1ns/10ps

module tb_deser_link_config_registers;
  logic clk_i, nrst_i, spread_strap_pin_i, reg_wr_i, reg_rd_i;
  logic [1:0] address_strap_a_i, address_strap_b_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic reg_rvalid_o, reg_wack_o, reg_err_o, frame_addr_valid_i;
  logic [6:0] frame_addr_i, peer_serializer_address_o, own_device_address_o;
  logic own_addr_hit_o, peer_addr_hit_o, lock_i, spread_enable_o;
  logic spread_wide_o, audio_port_enable_o, pixel_range_auto_o;
  logic [1:0] pixel_clock_range_o, serial_rate_range_o;
  logic [1:0] spread_recal_interval_o;
  logic serial_rate_auto_o, spread_recal_o, sawtooth_auto_o;
  logic [4:0] sawtooth_divider_o;
  logic [7:0] q, x, o;
  logic ok, e;
  int fail_count = 0;
  int compares = 0;
  logic [23:0] rows [11] = '{
    24'h00fffe,
    24'h01a5a4,
    24'h02ffdf,
    24'h028080,
    24'h02c6c6,
    24'h022909,
    24'h03ffdf,
    24'h038181,
    24'h030000,
    24'h024040,
    24'h034040
  };

  dlc_regs #(.RECAL_CYC_A(4), .RECAL_CYC_B(8), .RECAL_CYC_C(16)) i_dut (
    .clk_i, .nrst_i, .address_strap_a_i, .address_strap_b_i,
    .spread_strap_pin_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .reg_rvalid_o, .reg_wack_o, .reg_err_o, .frame_addr_i,
    .frame_addr_valid_i, .own_addr_hit_o, .peer_addr_hit_o, .lock_i,
    .peer_serializer_address_o, .own_device_address_o, .spread_enable_o,
    .spread_wide_o, .audio_port_enable_o, .pixel_clock_range_o,
    .pixel_range_auto_o, .serial_rate_range_o, .serial_rate_auto_o,
    .spread_recal_interval_o, .spread_recal_o, .sawtooth_divider_o,
    .sawtooth_auto_o
  );

  dlc_mcu_model i_mcu (
    .clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_wack_i(reg_wack_o),
    .reg_err_i(reg_err_o)
  );

  task automatic chk(input string n, input logic [7:0] ex,
                     input logic [7:0] g);
    compares++;
    if (g !== ex) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, ex, g);
    end
  endtask

  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] a, input logic [1:0] b,
                          input logic s);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    address_strap_a_i <= a;
    address_strap_b_i <= b;
    spread_strap_pin_i <= s;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
  endtask

  // Reads all four registers and compares them to packed defaults.
  task automatic chk_dflt(input logic [31:0] ex);
    for (int i = 0; i < 4; i++) begin
      i_mcu.xfer(8'(i), 8'h00, 1'b0, q, ok, e);
      chk("default", ex[8*i+:8], q);
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    nrst_i = 1'b0;
    address_strap_a_i = 2'h2;
    address_strap_b_i = 2'h1;
    spread_strap_pin_i = 1'b1;
    frame_addr_i = 7'h00;
    frame_addr_valid_i = 1'b0;
    lock_i = 1'b0;
    do_reset(2'h2, 2'h1, 1'b1);
    chk_dflt(32'h005f9484);
    foreach (rows[i]) begin
      i_mcu.xfer(rows[i][23:16], rows[i][15:8], 1'b1, q, ok, e);
      chk("wack", 8'h01, {7'h00, ok});
      i_mcu.xfer(rows[i][23:16], 8'h00, 1'b0, q, ok, e);
      chk("rdata", rows[i][7:0], q);
      x = rows[i][7:0];
      case (rows[i][23:16])
        8'h00: o = {peer_serializer_address_o, 1'b0};
        8'h01: o = {own_device_address_o, 1'b0};
        8'h02: begin
          o = {spread_wide_o, spread_enable_o, 1'b0, audio_port_enable_o,
               pixel_clock_range_o, serial_rate_range_o};
          x[7] = x[7] & x[6];
        end
        default: o = {spread_recal_interval_o, 1'b0, sawtooth_divider_o};
      endcase
      chk("fields", x, o);
      if (rows[i][23:16] == 8'h02) begin
        chk("auto", {6'h00, &x[3:2], &x[1:0]},
            {6'h00, pixel_range_auto_o, serial_rate_auto_o});
      end
    end
    i_mcu.xfer(8'h04, 8'h00, 1'b0, q, ok, e);
    chk("unmapped read", 8'h03, {6'h00, ok, e});
    chk("unmapped rdata", 8'h00, q);
    i_mcu.xfer(8'h07, 8'h55, 1'b1, q, ok, e);
    chk("unmapped write", 8'h01, {6'h00, ok, e});
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      frame_addr_i <= i ? 7'h7f : 7'h52;
      frame_addr_valid_i <= 1'b1;
      @(posedge clk_i);
      frame_addr_valid_i <= 1'b0;
      #1;
      chk("hits", i ? 8'h01 : 8'h02,
          {6'h00, own_addr_hit_o, peer_addr_hit_o});
    end
    @(posedge clk_i);
    lock_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("first recal", 8'h01, {7'h00, spread_recal_o});
    @(posedge clk_i);
    #1;
    chk("recal gap", 8'h00, {7'h00, spread_recal_o});
    repeat (3) @(posedge clk_i);
    #1;
    chk("next recal", 8'h01, {7'h00, spread_recal_o});
    i_mcu.xfer(8'h03, 8'h00, 1'b1, q, ok, e);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      #1;
      chk("once only", 8'h00, {7'h00, spread_recal_o});
    end
    @(posedge clk_i);
    lock_i <= 1'b0;
    do_reset(2'h0, 2'h2, 1'b0);
    chk_dflt(32'h001f1808);
    conclude();
  end
endmodule
